// >>> logic/motion_bank_pkg.sv
// Purpose: shared constants and carriers for the motion register bank
// Assumes: one 200 MHz clock, register numbers as word indices
// Notes: every register travels as a 32-bit word
package motion_bank_pkg;
	localparam int DATA_W = 32;
	localparam int REG_NUM_W = 8;

	// register numbers
	localparam logic [7:0] REG_ACCEL_RAMP = 8'h06;
	localparam logic [7:0] REG_MOTION_CURRENT = 8'h07;
	localparam logic [7:0] REG_IDLE_DELAY_MS = 8'h08;
	localparam logic [7:0] REG_IDLE_CURRENT = 8'h09;
	localparam logic [7:0] REG_ACTUAL_POSITION = 8'h0a;
	localparam logic [7:0] REG_RESERVED_11 = 8'h0b;
	localparam logic [7:0] REG_ACTUAL_VELOCITY = 8'h0c;
	localparam logic [7:0] REG_START_VELOCITY = 8'h0d;
	localparam logic [7:0] REG_GEAR_MULTIPLIER = 8'h0e;
	localparam logic [7:0] REG_GEAR_DIVIDER = 8'h0f;
	localparam logic [7:0] REG_ENCODER_POSITION = 8'h10;
	localparam logic [7:0] REG_RESERVED_17 = 8'h11;

	// values after reset
	localparam logic [31:0] RST_ACCEL_RAMP = 32'h0000_03e8;
	localparam logic [31:0] RST_MOTION_CURRENT = 32'h0000_01ff;
	localparam logic [31:0] RST_IDLE_DELAY_MS = 32'h0000_01f4;
	localparam logic [31:0] RST_IDLE_CURRENT = 32'h0000_0080;
	localparam logic [31:0] RST_START_VELOCITY = 32'h0000_0064;
	localparam logic [31:0] RST_GEAR_MULTIPLIER = 32'h0000_0640;
	localparam logic [31:0] RST_GEAR_DIVIDER = 32'h0000_07d0;
	localparam logic [31:0] RST_POSITION = 32'h0000_0000;

	// accepted ranges
	localparam logic [31:0] ACCEL_MIN = 32'h0000_0001;
	localparam logic [31:0] ACCEL_MAX = 32'h0007_a120;
	localparam logic [31:0] CURRENT_MAX = 32'h0000_05fd;
	localparam logic [31:0] IDLE_DELAY_MIN = 32'h0000_0001;
	localparam logic [31:0] IDLE_DELAY_MAX = 32'h0000_ffff;
	localparam logic [31:0] START_VEL_MIN = 32'h0000_0001;
	localparam logic [31:0] START_VEL_MAX = 32'h0004_93e0;
	localparam logic [31:0] GEAR_MIN = 32'hffff_8000;
	localparam logic [31:0] GEAR_MAX = 32'h0000_7fff;

	// millisecond tick
	localparam int CLK_HZ = 200_000_000;
	localparam int TICK_PERIOD_MS = 1;
	localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_PERIOD_MS;

	typedef struct packed {
		logic moving;
		logic direction;
		logic step;
		logic [31:0] velocity;
		logic encoder_fitted;
		logic encoder_step;
		logic encoder_direction;
	} motion_status_t;

	typedef struct packed {
		logic [31:0] accel_applied;
		logic [31:0] start_velocity;
		logic [31:0] gear_multiplier;
		logic [31:0] gear_divider;
		logic [31:0] drive_current;
		logic idle_active;
	} drive_cfg_t;
endpackage

// >>> logic/step_position_counter.sv
// Purpose: signed step counter with load, used for both position registers
// Assumes: step pulses on ref_clk, one cycle each
// Notes: a load in the same cycle as a step wins
`timescale 1ns/1ps
module step_position_counter #(
	parameter int W = 32
) (
	input wire logic ref_clk, // system clock
	input wire logic rstn, // async reset, active low
	input wire logic enable, // counting allowed
	input wire logic load, // master overwrite strobe
	input wire logic [W-1:0] load_value, // value to load
	input wire logic step, // one step pulse
	input wire logic dir, // 1 counts up, 0 down
	output logic [W-1:0] count // current position
);
	logic [W-1:0] next_count;

	assign next_count = load ? load_value :
		(enable && step) ? (dir ? count + W'(1) : count - W'(1)) : count;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end
endmodule

// >>> logic/stepper_motion_register_bank.sv
// Purpose: motion-parameter register bank, registers 6 to 17
// Assumes: register port and motion core share ref_clk
// Notes: read data appear one cycle after rd_en
// Contract
// R1: each register is carried as one 32-bit word on the register port.
// R2: accel written while moving applies only at stop or reversal.
// R3: after idle delay in ms, drive switches to idle current.
// R4: running current drives the motor while it moves, range 0 to 1533.
// R5: actual position is signed 32-bit, writable by master at any time.
// R6: acceleration starts from programmed start velocity, default 100.
// R7: gear factor is multiplier over divider, defaults 1600 and 2000.
// R8: with encoder fitted, encoder register reports signed 32-bit feedback.
// R9: reserved registers 11 and 17 read zero, writes ignored.
`timescale 1ns/1ps
module stepper_motion_register_bank
	import motion_bank_pkg::*;
#(
	parameter int TICK_CYCLES = MS_CYCLES
) (
	input wire logic ref_clk, // 200 MHz clock
	input wire logic rstn, // async reset, active low
	input wire logic [REG_NUM_W-1:0] reg_num, // register number
	input wire logic wr_en, // write strobe
	input wire logic [DATA_W-1:0] wr_data, // write word
	input wire logic rd_en, // read strobe
	output logic [DATA_W-1:0] rd_data, // read word, registered
	output logic rd_valid, // read data valid pulse
	input wire motion_status_t status, // from motion core
	output drive_cfg_t cfg // to motion core
);
	logic [31:0] accel_ramp;
	logic [31:0] accel_applied;
	logic [31:0] motion_current;
	logic [31:0] idle_delay_ms;
	logic [31:0] idle_current;
	logic [31:0] start_velocity;
	logic [31:0] gear_multiplier;
	logic [31:0] gear_divider;
	logic [31:0] actual_position;
	logic [31:0] encoder_position;
	logic prev_dir;
	logic [17:0] tick_count;
	logic ms_tick;
	logic [15:0] idle_ms;
	logic idle_active;
	logic [31:0] next_rd_data;

	// decode
	wire wr_accel = wr_en && reg_num == REG_ACCEL_RAMP;
	wire wr_run_cur = wr_en && reg_num == REG_MOTION_CURRENT;
	wire wr_idle_dly = wr_en && reg_num == REG_IDLE_DELAY_MS;
	wire wr_idle_cur = wr_en && reg_num == REG_IDLE_CURRENT;
	wire wr_pos = wr_en && reg_num == REG_ACTUAL_POSITION;
	wire wr_start = wr_en && reg_num == REG_START_VELOCITY;
	wire wr_gmul = wr_en && reg_num == REG_GEAR_MULTIPLIER;
	wire wr_gdiv = wr_en && reg_num == REG_GEAR_DIVIDER;
	wire wr_enc = wr_en && reg_num == REG_ENCODER_POSITION;

	// out-of-range writes are dropped so the core never sees an illegal value
	wire accel_ok = wr_data >= ACCEL_MIN && wr_data <= ACCEL_MAX;
	wire current_ok = wr_data <= CURRENT_MAX;
	wire idle_dly_ok = wr_data >= IDLE_DELAY_MIN && wr_data <= IDLE_DELAY_MAX;
	wire start_ok = wr_data >= START_VEL_MIN && wr_data <= START_VEL_MAX;
	wire gear_ok = $signed(wr_data) >= $signed(GEAR_MIN) &&
		$signed(wr_data) <= $signed(GEAR_MAX);

	// R2 stop or reversal
	wire reversal = status.moving && (status.direction != prev_dir);
	wire accel_apply = !status.moving || reversal;

	wire tick_wrap = tick_count == 18'(TICK_CYCLES - 1);
	// R3 idle delay elapsed
	wire idle_reached = {16'h0000, idle_ms} >= idle_delay_ms;

	// one short process per register keeps each write path easy to audit
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			accel_ramp <= RST_ACCEL_RAMP;
		end else if (wr_accel && accel_ok) begin
			accel_ramp <= wr_data;
		end
	end

	// R4 running current range
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			motion_current <= RST_MOTION_CURRENT;
		end else if (wr_run_cur && current_ok) begin
			motion_current <= wr_data;
		end
	end

	// R3 idle delay range
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			idle_delay_ms <= RST_IDLE_DELAY_MS;
		end else if (wr_idle_dly && idle_dly_ok) begin
			idle_delay_ms <= wr_data;
		end
	end

	// R3 standby current range
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			idle_current <= RST_IDLE_CURRENT;
		end else if (wr_idle_cur && current_ok) begin
			idle_current <= wr_data;
		end
	end

	// R6 start velocity range
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			start_velocity <= RST_START_VELOCITY;
		end else if (wr_start && start_ok) begin
			start_velocity <= wr_data;
		end
	end

	// R7 gear multiplier range
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			gear_multiplier <= RST_GEAR_MULTIPLIER;
		end else if (wr_gmul && gear_ok) begin
			gear_multiplier <= wr_data;
		end
	end

	// R7 gear divider range
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			gear_divider <= RST_GEAR_DIVIDER;
		end else if (wr_gdiv && gear_ok) begin
			gear_divider <= wr_data;
		end
	end

	// R2 hold new ramp until stop or reversal
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			accel_applied <= RST_ACCEL_RAMP;
			prev_dir <= 1'b0;
		end else begin
			prev_dir <= status.direction;
			if (accel_apply) begin
				accel_applied <= accel_ramp;
			end
		end
	end

	// millisecond enable for the idle timer
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			tick_count <= '0;
			ms_tick <= 1'b0;
		end else begin
			ms_tick <= tick_wrap;
			tick_count <= tick_wrap ? '0 : tick_count + 18'd1;
		end
	end

	// R3 idle timer
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			idle_ms <= '0;
			idle_active <= 1'b0;
		end else if (status.moving) begin
			idle_ms <= '0;
			idle_active <= 1'b0;
		end else if (idle_reached) begin
			idle_active <= 1'b1;
		end else if (ms_tick) begin
			idle_ms <= idle_ms + 16'd1;
		end
	end

	// R5 master write wins over a step
	step_position_counter #(
		.W(32)
	) u_actual_position (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.enable(1'b1),
		.load(wr_pos),
		.load_value(wr_data),
		.step(status.step),
		.dir(status.direction),
		.count(actual_position)
	);

	// R8 feedback counts only with encoder
	step_position_counter #(
		.W(32)
	) u_encoder_position (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.enable(status.encoder_fitted),
		.load(wr_enc),
		.load_value(wr_data),
		.step(status.encoder_step),
		.dir(status.encoder_direction),
		.count(encoder_position)
	);

	// R1 word read mux
	always_comb begin
		next_rd_data = 32'h0000_0000;
		unique case (reg_num)
			REG_ACCEL_RAMP: next_rd_data = accel_ramp;
			REG_MOTION_CURRENT: next_rd_data = motion_current;
			REG_IDLE_DELAY_MS: next_rd_data = idle_delay_ms;
			REG_IDLE_CURRENT: next_rd_data = idle_current;
			REG_ACTUAL_POSITION: next_rd_data = actual_position;
			REG_ACTUAL_VELOCITY: next_rd_data = status.velocity;
			REG_START_VELOCITY: next_rd_data = start_velocity;
			REG_GEAR_MULTIPLIER: next_rd_data = gear_multiplier;
			REG_GEAR_DIVIDER: next_rd_data = gear_divider;
			// R8 zero without encoder
			REG_ENCODER_POSITION: next_rd_data = status.encoder_fitted ? encoder_position : '0;
			// R9 reserved read zero
			REG_RESERVED_11, REG_RESERVED_17: next_rd_data = 32'h0000_0000;
			default: next_rd_data = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rd_data <= '0;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= rd_en;
			if (rd_en) begin
				rd_data <= next_rd_data;
			end
		end
	end

	assign cfg.accel_applied = accel_applied;
	// R6 start velocity to ramp
	assign cfg.start_velocity = start_velocity;
	// R7 gear ratio operands
	assign cfg.gear_multiplier = gear_multiplier;
	assign cfg.gear_divider = gear_divider;
	// R4 running current while moving
	assign cfg.drive_current = idle_active ? idle_current : motion_current;
	assign cfg.idle_active = idle_active;
endmodule

// >>> sim/motion_bank_checker.sv
// Purpose: port-level checks for the motion register bank
// Assumes: one clock, reset active low
// Notes: attached to every bank instance by the bind below
`timescale 1ns/1ps
module motion_bank_checker
	import motion_bank_pkg::*;
#(
	parameter int TICK_CYCLES = MS_CYCLES
) (
	input wire logic ref_clk, // clock
	input wire logic rstn, // reset
	input wire logic [REG_NUM_W-1:0] reg_num, // number
	input wire logic wr_en, // write
	input wire logic [DATA_W-1:0] wr_data, // word in
	input wire logic rd_en, // read
	input wire logic [DATA_W-1:0] rd_data, // word out
	input wire logic rd_valid, // valid
	input wire motion_status_t status, // status
	input wire drive_cfg_t cfg // config
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	wire acc_ok = wr_data >= ACCEL_MIN && wr_data <= ACCEL_MAX;
	wire wr_acc = wr_en && reg_num == REG_ACCEL_RAMP && acc_ok;
	wire rsvd = reg_num == REG_RESERVED_11 || reg_num == REG_RESERVED_17;
	// two stopped cycles: write lands, then gets applied
	sequence acc_wr_idle;
		wr_acc && !status.moving ##1 !status.moving;
	endsequence
	accel_stop_a: assert property (acc_wr_idle |=> cfg.accel_applied == $past(wr_data, 2))
		else $error("ramp not applied");
	accel_hold_a: assert property (
		status.moving && status.direction == $past(status.direction)
		|=> $stable(cfg.accel_applied)) else $error("ramp changed mid move");
	rd_pulse_a: assert property (rd_en |=> rd_valid)
		else $error("no read valid");
	rd_quiet_a: assert property (!rd_en |=> !rd_valid && $stable(rd_data))
		else $error("read port moved");
	rsvd_zero_a: assert property (rd_en && rsvd |=> rd_data == 32'h0000_0000)
		else $error("reserved read nonzero");
	idle_clear_a: assert property (status.moving |=> !cfg.idle_active)
		else $error("idle while moving");
	run_current_a: assert property (
		wr_en && reg_num == REG_MOTION_CURRENT && wr_data <= CURRENT_MAX ##1 !cfg.idle_active
		|-> cfg.drive_current == $past(wr_data)) else $error("run current wrong");
	gear_mult_a: assert property (
		wr_en && reg_num == REG_GEAR_MULTIPLIER && wr_data <= GEAR_MAX
		|=> cfg.gear_multiplier == $past(wr_data)) else $error("multiplier wrong");
	start_vel_a: assert property (
		wr_en && reg_num == REG_START_VELOCITY && wr_data >= START_VEL_MIN &&
		wr_data <= START_VEL_MAX
		|=> cfg.start_velocity == $past(wr_data)) else $error("start velocity wrong");
	enc_absent_a: assert property (
		rd_en && reg_num == REG_ENCODER_POSITION && !status.encoder_fitted
		|=> rd_data == 32'h0000_0000) else $error("encoder read without option");
endmodule
bind stepper_motion_register_bank motion_bank_checker #(.TICK_CYCLES(TICK_CYCLES)) checker_inst (
	.ref_clk, .rstn, .reg_num, .wr_en, .wr_data, .rd_en, .rd_data, .rd_valid, .status, .cfg);

// >>> sim/motion_core_model.sv
// Purpose: behavioural motion core feeding the bank
// Assumes: one step per cycle while running
// Notes: fixed velocity while running, zero when stopped
`timescale 1ns/1ps
module motion_core_model
	import motion_bank_pkg::*;
(
	input wire logic ref_clk, // clock
	input wire logic rstn, // reset
	input wire logic run, // move request
	input wire logic dir, // 1 counts up
	input wire logic enc_on, // encoder fitted
	output motion_status_t status // to bank
);
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			status <= '0;
		end else begin
			status.moving <= run;
			status.direction <= dir;
			status.step <= run;
			status.velocity <= run ? 32'h0000_2710 : 32'h0000_0000;
			status.encoder_fitted <= enc_on;
			status.encoder_step <= run & enc_on;
			status.encoder_direction <= dir;
		end
	end
endmodule

// >>> sim/stepper_motion_register_bank_tb.sv
// Purpose: register tests for the motion bank
// Assumes: ms tick cut to 10 cycles for speed
// Notes: model supplies motion status
`timescale 1ns/1ps
module stepper_motion_register_bank_tb;
	import motion_bank_pkg::*;
	logic ref_clk = '0, rstn = '0, wr_en = '0, rd_en = '0, run = '0, dir = '0, enc_on = '0;
	logic rd_valid;
	logic [7:0] reg_num = 8'h00;
	logic [31:0] wr_data = 32'h0000_0000, rd_data;
	motion_status_t status;
	drive_cfg_t cfg;
	int bad_count = 0, checks = 0, cyc = 0;
	logic [7:0] num [7] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0d, 8'h0e, 8'h0f};
	logic [7:0] rsv [4] = '{8'h0b, 8'h11, 8'h0c, 8'h20};
	logic [31:0] dft [7] = '{RST_ACCEL_RAMP, RST_MOTION_CURRENT, RST_IDLE_DELAY_MS,
		RST_IDLE_CURRENT, RST_START_VELOCITY, RST_GEAR_MULTIPLIER, RST_GEAR_DIVIDER};
	logic [31:0] ok [7] = '{ACCEL_MAX, CURRENT_MAX, 32'h0000_0003, 32'h0000_0040,
		START_VEL_MAX, GEAR_MAX, 32'h0000_0001};
	logic [31:0] nok [7] = '{32'h0000_0000, 32'h0000_05fe, 32'h0000_0000, 32'h0000_05fe,
		32'h0004_93e1, 32'h0000_8000, 32'hffff_7fff};
	stepper_motion_register_bank #(.TICK_CYCLES(10)) stepper_motion_register_bank_inst (
		.ref_clk, .rstn, .reg_num, .wr_en, .wr_data, .rd_en, .rd_data, .rd_valid, .status, .cfg);
	motion_core_model motion_core_model_inst (.ref_clk, .rstn, .run, .dir, .enc_on, .status);
	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			summarize();
		end
	end
	task summarize();
		if (bad_count == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task mv(input logic r, input logic d, input logic e);
		@(posedge ref_clk);
		run <= r;
		dir <= d;
		enc_on <= e;
	endtask
	task wr(input logic [7:0] n, input logic [31:0] d);
		@(posedge ref_clk);
		reg_num <= n;
		wr_data <= d;
		wr_en <= 1'h1;
		@(posedge ref_clk);
		wr_en <= 1'h0;
	endtask
	task rd(input logic [7:0] n, input logic [31:0] e);
		@(posedge ref_clk);
		reg_num <= n;
		rd_en <= 1'h1;
		@(posedge ref_clk);
		rd_en <= 1'h0;
		#1;
		chk({31'h0, rd_valid}, 32'h0000_0001);
		chk(rd_data, e);
	endtask
	initial begin
		repeat (20) @(posedge ref_clk);
		chk(cfg.drive_current, RST_MOTION_CURRENT);
		chk(cfg.gear_divider, RST_GEAR_DIVIDER);
		chk(cfg.start_velocity, RST_START_VELOCITY);
		rstn <= 1'h1;
		for (int i = 0; i < 7; i++) rd(num[i], dft[i]);
		for (int i = 0; i < 7; i++) wr(num[i], ok[i]);
		for (int i = 0; i < 7; i++) wr(num[i], nok[i]);
		for (int i = 0; i < 7; i++) rd(num[i], ok[i]);
		chk(cfg.start_velocity, START_VEL_MAX);
		chk(cfg.gear_multiplier, GEAR_MAX);
		chk(cfg.gear_divider, 32'h0000_0001);
		for (int i = 0; i < 4; i++) wr(rsv[i], 32'hffff_ffff);
		for (int i = 0; i < 4; i++) rd(rsv[i], 32'h0000_0000);
		chk(cfg.drive_current, 32'h0000_0040);
		mv(1'h1, 1'h1, 1'h0);
		wt(3);
		chk(cfg.drive_current, CURRENT_MAX);
		mv(1'h0, 1'h1, 1'h1);
		wt(15);
		chk({31'h0, cfg.idle_active}, 32'h0000_0000);
		wt(30);
		chk(cfg.drive_current, 32'h0000_0040);
		wr(8'h0a, 32'h8000_0005);
		wr(8'h10, 32'h0000_0010);
		mv(1'h1, 1'h0, 1'h1);
		wt(4);
		mv(1'h0, 1'h0, 1'h1);
		rd(8'h0a, 32'h8000_0000);
		rd(8'h10, 32'h0000_000b);
		mv(1'h1, 1'h1, 1'h0);
		rd(8'h10, 32'h0000_0000);
		wr(8'h0a, 32'h0000_0000);
		mv(1'h0, 1'h1, 1'h0);
		rd(8'h0a, 32'h0000_0002);
		mv(1'h1, 1'h1, 1'h0);
		wr(8'h06, 32'h0000_1234);
		wt(3);
		chk(cfg.accel_applied, ACCEL_MAX);
		mv(1'h1, 1'h0, 1'h0);
		wt(3);
		chk(cfg.accel_applied, 32'h0000_1234);
		rd(8'h0c, 32'h0000_2710);
		wr(8'h06, 32'h0000_2222);
		wt(3);
		chk(cfg.accel_applied, 32'h0000_1234);
		mv(1'h0, 1'h0, 1'h0);
		wt(3);
		chk(cfg.accel_applied, 32'h0000_2222);
		@(posedge ref_clk);
		rstn <= 1'h0;
		wt(2);
		chk(cfg.accel_applied, RST_ACCEL_RAMP);
		chk(cfg.drive_current, RST_MOTION_CURRENT);
		@(posedge ref_clk);
		rstn <= 1'h1;
		rd(8'h06, RST_ACCEL_RAMP);
		rd(8'h0a, RST_POSITION);
		summarize();
	end
endmodule
